/* File: include/aut_pkg.sv */
/*
  Constants, register map, field positions and bus carrier of the
  asynchronous serial transmitter and receiver.
  Assumes one clock (the instruction cycle) and a plain register port.
*/
package aut_pkg;
  // register offsets
  localparam logic [3:0] AUT_OFS_IRQ_FLAGS = 4'h0;
  localparam logic [3:0] AUT_OFS_IRQ_ENABLES = 4'h1;
  localparam logic [3:0] AUT_OFS_IRQ_PRIORITY = 4'h2;
  localparam logic [3:0] AUT_OFS_RX_STATUS = 4'h3;
  localparam logic [3:0] AUT_OFS_TX_BUFFER = 4'h4;
  localparam logic [3:0] AUT_OFS_TX_STATUS = 4'h5;
  localparam logic [3:0] AUT_OFS_BAUD_CONTROL = 4'h6;
  localparam logic [3:0] AUT_OFS_DIV_HIGH = 4'h7;
  localparam logic [3:0] AUT_OFS_DIV_LOW = 4'h8;
  localparam logic [3:0] AUT_OFS_RX_BUFFER = 4'h9;
  // flag, enable and priority bits
  localparam int AUT_B_RX_IRQ = 5;
  localparam int AUT_B_TX_IRQ = 4;
  // receive status/control bits
  localparam int AUT_B_PORT_EN = 7;
  localparam int AUT_B_RX9 = 6;
  localparam int AUT_B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int AUT_B_ADDR_DET = 3;
  localparam int AUT_B_FRAMING_ERROR_FLAG = 2;
  localparam int AUT_B_OVERRUN_ERROR_FLAG = 1;
  localparam int AUT_B_RX_NINTH_BIT = 0;
  // transmit status/control bits
  localparam int AUT_B_TX9 = 6;
  localparam int AUT_B_TRANSMIT_ENABLE = 5;
  localparam int AUT_B_SYNC = 4;
  localparam int AUT_B_HIGH_SPEED = 2;
  localparam int AUT_B_SHIFT_EMPTY = 1;
  localparam int AUT_B_TX_NINTH_BIT = 0;
  // baud control bits
  localparam int AUT_B_WIDE_DIV = 3;
  // reset values
  localparam logic [7:0] AUT_RST_BYTE = 8'h00;
  // oversampling
  localparam int AUT_OVERSAMPLE = 16;
  localparam logic [3:0] AUT_LAST_TICK = 4'hF;
  localparam logic [3:0] AUT_MID_TICK = 4'h7;
  localparam logic [1:0] AUT_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] AUT_BITS_8 = 4'h8;
  localparam logic [3:0] AUT_BITS_9 = 4'h9;

  typedef enum logic [1:0] {
    AUT_IDLE = 2'b00,
    AUT_START = 2'b01,
    AUT_DATA = 2'b11,
    AUT_STOP = 2'b10
  } aut_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } aut_bus_req_s;
endpackage

/* File: hw/aut_uart.sv */
/*
  Asynchronous serial transmitter and receiver with its register file.
  Assumes core_clk is the instruction cycle, rx_in is already synchronous,
  and software drives the register port one strobe at a time.
*/
`timescale 1ns/1ps
// What this block does
// - load shifter only after stop bit done
// - buffer-to-shifter move takes one cycle, sets flag
// - buffer-empty flag not software clearable
// - flag clears two cycles after buffer write
// - transmit request is flag and enable
// - readable shift-empty status, no interrupt
// - transmit enable sets buffer-empty flag
// - ninth transmit bit from control field
// - buffer write while enabled starts transmission
// - sixteen ticks per received bit, one sample at mid-bit
// - reception only while continuous enable set
// - character done sets flag, request if enabled
// - status shows ninth bit and errors
// - reading data removes character, clears flag
// - clearing continuous enable clears overrun error, not framing error
// - nine-bit select gives nine data bits
// - address detect keeps data characters out, with nine-bit select only
// - unimplemented bits read zero
// - start, eight or nine data, stop
// - least significant bit first, shared format
module aut_uart (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire aut_pkg::aut_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  // serial pins
  input wire logic rx_in,
  output logic tx_out,
  // interrupt requests
  output logic tx_irq_req,
  output logic rx_irq_req,
  output logic rx_irq_priority
);
  import aut_pkg::*;

  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  function automatic logic hit(input aut_bus_req_s r, input logic [3:0] ofs);
    hit = r.addr == ofs;
  endfunction

  // software registers
  logic [7:0] ctrl_rx_q;
  logic [7:0] ctrl_tx_q;
  logic tx_ie_q;
  logic rx_ie_q;
  logic rx_ip_q;
  logic wide_q;
  logic [7:0] div_hi_q;
  logic [7:0] div_lo_q;

  wire wr = bus_req.we;
  wire port_on = ctrl_rx_q[AUT_B_PORT_EN] & ~ctrl_tx_q[AUT_B_SYNC];
  wire rx9 = ctrl_rx_q[AUT_B_RX9];
  wire continuous_receive_enable = ctrl_rx_q[AUT_B_CONTINUOUS_RECEIVE_ENABLE] & port_on;
  wire addr_det = ctrl_rx_q[AUT_B_ADDR_DET];
  wire transmit_enable = ctrl_tx_q[AUT_B_TRANSMIT_ENABLE] & port_on;
  wire tx9 = ctrl_tx_q[AUT_B_TX9];
  wire high_speed = ctrl_tx_q[AUT_B_HIGH_SPEED];

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_rx_q <= AUT_RST_BYTE;
      ctrl_tx_q <= AUT_RST_BYTE;
      tx_ie_q <= 1'b0;
      rx_ie_q <= 1'b0;
      rx_ip_q <= 1'b0;
      wide_q <= 1'b0;
      div_hi_q <= AUT_RST_BYTE;
      div_lo_q <= AUT_RST_BYTE;
    end else if (wr) begin
      if (hit(bus_req, AUT_OFS_RX_STATUS)) begin
        ctrl_rx_q <= bus_req.wdata;
      end
      if (hit(bus_req, AUT_OFS_TX_STATUS)) begin
        ctrl_tx_q <= bus_req.wdata;
      end
      if (hit(bus_req, AUT_OFS_IRQ_ENABLES)) begin
        tx_ie_q <= bus_req.wdata[AUT_B_TX_IRQ];
        rx_ie_q <= bus_req.wdata[AUT_B_RX_IRQ];
      end
      if (hit(bus_req, AUT_OFS_IRQ_PRIORITY)) begin
        rx_ip_q <= bus_req.wdata[AUT_B_RX_IRQ];
      end
      if (hit(bus_req, AUT_OFS_BAUD_CONTROL)) begin
        wide_q <= bus_req.wdata[AUT_B_WIDE_DIV];
      end
      if (hit(bus_req, AUT_OFS_DIV_HIGH)) begin
        div_hi_q <= bus_req.wdata;
      end
      if (hit(bus_req, AUT_OFS_DIV_LOW)) begin
        div_lo_q <= bus_req.wdata;
      end
    end
  end

  // baud generator: counter wraps at the divisor; without high speed it
  // runs at 64x the bit rate, so a /4 prescale keeps a 16x sample tick
  logic [15:0] brg_q;
  logic [1:0] pre_q;
  wire [15:0] brg_limit = wide_q ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  wire brg_wrap = brg_q >= brg_limit;
  wire tick = brg_wrap & (high_speed | (pre_q == AUT_PRESCALE_LAST));
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      brg_q <= 16'h0000;
      pre_q <= 2'h0;
    end else if (!port_on) begin
      brg_q <= 16'h0000;
      pre_q <= 2'h0;
    end else if (brg_wrap) begin
      brg_q <= 16'h0000;
      pre_q <= pre_q + 2'h1;
    end else begin
      brg_q <= brg_q + 16'h0001;
    end
  end

  // transmit buffer
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic tx_flag_q;
  aut_state_e tx_st_q;
  wire tx_write = wr & hit(bus_req, AUT_OFS_TX_BUFFER) & transmit_enable;
  wire tx_load = tx_full_q & (tx_st_q == AUT_IDLE) & transmit_enable;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_buf_q <= AUT_RST_BYTE;
      tx_full_q <= 1'b0;
      tx_flag_q <= 1'b1;
    end else begin
      if (tx_write) begin
        tx_buf_q <= bus_req.wdata;
      end
      if (!transmit_enable) begin
        tx_full_q <= 1'b0;
      end else if (tx_write) begin
        tx_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_full_q <= 1'b0;
      end
      // one cycle behind the buffer state: stale right after a write
      tx_flag_q <= ~tx_full_q;
    end
  end
  assign tx_irq_req = tx_flag_q & tx_ie_q;

  // transmit shifter
  logic [8:0] tx_sh_q;
  logic [3:0] tx_tick_q;
  logic [3:0] tx_bit_q;
  logic tx_q;
  wire tx_bit_end = tick & (tx_tick_q == AUT_LAST_TICK);
  wire [3:0] tx_nbits = tx9 ? AUT_BITS_9 : AUT_BITS_8;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_st_q <= AUT_IDLE;
      tx_sh_q <= 9'h000;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_q <= 1'b1;
    end else if (!transmit_enable) begin
      tx_st_q <= AUT_IDLE;
      tx_q <= 1'b1;
    end else begin
      if (tick) begin
        tx_tick_q <= tx_tick_q + 4'h1;
      end
      unique case (tx_st_q)
        AUT_IDLE: begin
          tx_q <= 1'b1;
          if (tx_load) begin
            tx_sh_q <= {ctrl_tx_q[AUT_B_TX_NINTH_BIT], tx_buf_q};
            tx_tick_q <= 4'h0;
            tx_q <= 1'b0;
            tx_st_q <= AUT_START;
          end
        end
        AUT_START: begin
          if (tx_bit_end) begin
            tx_q <= tx_sh_q[0];
            tx_bit_q <= 4'h1;
            tx_st_q <= AUT_DATA;
          end
        end
        AUT_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit_q == tx_nbits) begin
              tx_q <= 1'b1;
              tx_st_q <= AUT_STOP;
            end else begin
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              tx_q <= tx_sh_q[1];
              tx_bit_q <= tx_bit_q + 4'h1;
            end
          end
        end
        AUT_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= AUT_IDLE;
          end
        end
      endcase
    end
  end
  assign tx_out = tx_q;
  wire shift_empty = tx_st_q == AUT_IDLE;

  // receiver, sampled at mid-bit of 16 ticks
  aut_state_e rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic rx_done;
  logic [7:0] rx_buf_q;
  logic rx_buf9_q;
  logic rx_framing_error_flag_q;
  logic rx_full_q;
  logic overrun_error_flag_q;
  wire [3:0] rx_nbits = rx9 ? AUT_BITS_9 : AUT_BITS_8;
  wire rx_mid = tick & (rx_tick_q == AUT_LAST_TICK);
  wire [8:0] rx_char = rx9 ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_st_q <= AUT_IDLE;
      rx_sh_q <= 9'h000;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 4'h0;
    end else if (!continuous_receive_enable || overrun_error_flag_q) begin
      rx_st_q <= AUT_IDLE;
    end else begin
      if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      unique case (rx_st_q)
        AUT_IDLE: begin
          if (tick && !rx_in) begin
            rx_tick_q <= 4'h0;
            rx_st_q <= AUT_START;
          end
        end
        AUT_START: begin
          if (tick && rx_tick_q == AUT_MID_TICK) begin
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            // a glitch shorter than half a bit is not a start
            rx_st_q <= rx_in ? AUT_IDLE : AUT_DATA;
          end
        end
        AUT_DATA: begin
          if (rx_mid) begin
            rx_sh_q <= {rx_in, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q + 4'h1 == rx_nbits) begin
              rx_st_q <= AUT_STOP;
            end
          end
        end
        AUT_STOP: begin
          if (rx_mid) begin
            rx_st_q <= AUT_IDLE;
          end
        end
      endcase
    end
  end
  assign rx_done = continuous_receive_enable & ~overrun_error_flag_q & (rx_st_q == AUT_STOP) & rx_mid;

  // receive buffer; a new character in the read cycle is kept
  wire rx_read = bus_req.re & hit(bus_req, AUT_OFS_RX_BUFFER);
  wire rx_keep = ~addr_det | ~rx9 | rx_char[8];
  wire rx_accept = rx_done & rx_keep;
  wire rx_overrun = rx_accept & rx_full_q & ~rx_read;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_buf_q <= AUT_RST_BYTE;
      rx_buf9_q <= 1'b0;
      rx_framing_error_flag_q <= 1'b0;
      rx_full_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
    end else begin
      if (rx_accept && !rx_overrun) begin
        rx_buf_q <= rx_char[7:0];
        rx_buf9_q <= rx_char[8];
        rx_framing_error_flag_q <= ~rx_in;
        rx_full_q <= 1'b1;
      end else if (rx_read) begin
        rx_full_q <= 1'b0;
      end
      if (!continuous_receive_enable) begin
        overrun_error_flag_q <= 1'b0;
      end else if (rx_overrun) begin
        overrun_error_flag_q <= 1'b1;
      end
    end
  end
  assign rx_irq_req = rx_full_q & rx_ie_q;
  assign rx_irq_priority = rx_ip_q;

  // read mux; unimplemented bits read zero
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    unique case (bus_req.addr)
      AUT_OFS_IRQ_FLAGS: begin
        rmux[AUT_B_RX_IRQ] = rx_full_q;
        rmux[AUT_B_TX_IRQ] = tx_flag_q;
      end
      AUT_OFS_IRQ_ENABLES: begin
        rmux[AUT_B_RX_IRQ] = rx_ie_q;
        rmux[AUT_B_TX_IRQ] = tx_ie_q;
      end
      AUT_OFS_IRQ_PRIORITY: rmux[AUT_B_RX_IRQ] = rx_ip_q;
      AUT_OFS_RX_STATUS: begin
        rmux[AUT_B_PORT_EN] = ctrl_rx_q[AUT_B_PORT_EN];
        rmux[AUT_B_RX9] = rx9;
        rmux[AUT_B_CONTINUOUS_RECEIVE_ENABLE] = ctrl_rx_q[AUT_B_CONTINUOUS_RECEIVE_ENABLE];
        rmux[AUT_B_ADDR_DET] = addr_det;
        rmux[AUT_B_FRAMING_ERROR_FLAG] = rx_framing_error_flag_q & rx_full_q;
        rmux[AUT_B_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
        rmux[AUT_B_RX_NINTH_BIT] = rx_buf9_q & rx9;
      end
      AUT_OFS_TX_BUFFER: rmux = tx_buf_q;
      AUT_OFS_TX_STATUS: begin
        rmux[AUT_B_TX9] = tx9;
        rmux[AUT_B_TRANSMIT_ENABLE] = ctrl_tx_q[AUT_B_TRANSMIT_ENABLE];
        rmux[AUT_B_SYNC] = ctrl_tx_q[AUT_B_SYNC];
        rmux[AUT_B_HIGH_SPEED] = high_speed;
        rmux[AUT_B_SHIFT_EMPTY] = shift_empty;
        rmux[AUT_B_TX_NINTH_BIT] = ctrl_tx_q[AUT_B_TX_NINTH_BIT];
      end
      AUT_OFS_BAUD_CONTROL: rmux[AUT_B_WIDE_DIV] = wide_q;
      AUT_OFS_DIV_HIGH: rmux = div_hi_q;
      AUT_OFS_DIV_LOW: rmux = div_lo_q;
      AUT_OFS_RX_BUFFER: rmux = rx_buf_q;
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= bus_req.re ? rmux : 8'h00;
    end
  end
endmodule

/* File: test/aut_uart_chk.sv */
/*
  Port assertions of the serial block.
  Assumes the register map of aut_pkg; bound to every aut_uart.
*/
`timescale 1ns/1ps
module aut_uart_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire aut_pkg::aut_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata,
  // serial pins and requests
  input wire logic rx_in,
  input wire logic tx_out,
  input wire logic tx_irq_req,
  input wire logic rx_irq_req,
  input wire logic rx_irq_priority
);
  import aut_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic rd_flags = bus_req.re && bus_req.addr == AUT_OFS_IRQ_FLAGS;
  wire logic rd_data = bus_req.re && bus_req.addr == AUT_OFS_RX_BUFFER;
  wire logic wr_en = bus_req.we && bus_req.addr == AUT_OFS_IRQ_ENABLES;
  sequence s_start_bit;
    !tx_out [*8];
  endsequence
  sequence s_recent_write;
    $past(bus_req.we) || $past(bus_req.we, 2) || $past(bus_req.we, 3);
  endsequence
  a_rdata_quiet: assert property (!bus_req.re |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (bus_req.re && bus_req.addr > AUT_OFS_RX_BUFFER
    |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flags_spare: assert property (rd_flags |=> (bus_rdata & 8'hCF) == 8'h00)
    else $error("spare flag bits not zero");
  a_start_bit: assert property ($fell(tx_out) |-> s_start_bit)
    else $error("start bit too short");
  a_rx_masked: assert property (wr_en && !bus_req.wdata[AUT_B_RX_IRQ] |=> !rx_irq_req)
    else $error("receive request while disabled");
  a_tx_masked: assert property (wr_en && !bus_req.wdata[AUT_B_TX_IRQ] |=> !tx_irq_req)
    else $error("transmit request while disabled");
  a_rx_read_clr: assert property (rd_data && rx_irq_req |=> !rx_irq_req)
    else $error("receive request kept after data read");
  a_tx_flag_sw: assert property ($fell(tx_irq_req) |-> s_recent_write)
    else $error("transmit request dropped without a write");
endmodule

bind aut_uart aut_uart_chk u_chk (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .rx_in(rx_in), .tx_out(tx_out), .tx_irq_req(tx_irq_req),
  .rx_irq_req(rx_irq_req), .rx_irq_priority(rx_irq_priority));

/* File: test/aut_remote_node.sv */
/*
  Remote serial node: sends characters into the block, collects its output.
  Assumes sixteen clock cycles per bit (divisor 0, high speed).
*/
`timescale 1ns/1ps
module aut_remote_node (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic tx_out,
  output logic rx_line
);
  localparam int BIT_CYC = 16;
  int nbits = 8;
  logic [8:0] got_q[$];
  logic stop_bad = 1'b0;
  initial rx_line = 1'b1;
  // caller enters at a rising edge
  task automatic send(input logic [8:0] w, input int n, input logic stop);
    rx_line <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= w[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    rx_line <= stop;
    repeat (BIT_CYC) @(posedge core_clk);
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask
  // mid-bit sampling tolerates the one-cycle start phase
  initial begin
    logic [8:0] w;
    forever begin
      @(negedge tx_out);
      w = 9'h000;
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        w[i] = tx_out;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      if (tx_out !== 1'b1) stop_bad = 1'b1;
      got_q.push_back(w);
    end
  end
endmodule

/* File: test/aut_uart_tb.sv */
/*
  Self-checking bench of the serial block against the remote node.
  Assumes divisor 0 with high speed: sixteen cycles per bit.
*/
`timescale 1ns/1ps
module aut_uart_tb;
  import aut_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  aut_bus_req_s bus_req = '0;
  logic [7:0] bus_rdata;
  logic rx_line;
  logic tx_out;
  logic tx_irq_req;
  logic rx_irq_req;
  logic rx_irq_priority;
  logic [8:0] rd_q;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  aut_uart u_dut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .rx_in(rx_line), .tx_out(tx_out), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req),
    .rx_irq_priority(rx_irq_priority));
  aut_remote_node u_node (.core_clk(core_clk), .tx_out(tx_out), .rx_line(rx_line));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // callers enter at least one edge after the cause, so the level has settled
  task automatic pchk(input string n, input logic s, input logic e);
    chk(n, {8'h00, s}, {8'h00, e});
    @(posedge core_clk);
  endtask
  // bus tasks enter and leave at a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.we <= 1'b1;
    @(posedge core_clk);
    bus_req.we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    bus_req.addr <= a;
    bus_req.re <= 1'b1;
    @(posedge core_clk);
    bus_req.re <= 1'b0;
    #1 rd_q = {1'b0, bus_rdata};
    @(posedge core_clk);
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 600 && u_node.got_q.size() < n; i++) @(posedge core_clk);
    chk("frames seen", 9'(u_node.got_q.size()), 9'(n));
  endtask
  task automatic t_regs();
    rd(AUT_OFS_IRQ_FLAGS);
    chk("flags reset", rd_q, 9'h010);
    rd(AUT_OFS_TX_STATUS);
    chk("shift empty reset", rd_q, 9'h002);
    rd(4'hF);
    chk("unmapped", rd_q, 9'h000);
    wr(AUT_OFS_BAUD_CONTROL, 8'hFF);
    rd(AUT_OFS_BAUD_CONTROL);
    chk("baud spare bits", rd_q, 9'h008);
    wr(AUT_OFS_BAUD_CONTROL, 8'h00);
    wr(AUT_OFS_DIV_LOW, 8'h00);
    wr(AUT_OFS_DIV_HIGH, 8'h00);
    wr(AUT_OFS_IRQ_ENABLES, 8'h30);
    wr(AUT_OFS_IRQ_PRIORITY, 8'h20);
    pchk("rx priority", rx_irq_priority, 1'b1);
    wr(AUT_OFS_TX_STATUS, 8'h24);
    wr(AUT_OFS_RX_STATUS, 8'h80);
  endtask
  task automatic t_tx();
    wr(AUT_OFS_TX_BUFFER, 8'hA5);
    repeat (2) @(posedge core_clk);
    rd(AUT_OFS_TX_STATUS);
    chk("shift busy", rd_q, 9'h024);
    rd(AUT_OFS_IRQ_FLAGS);
    chk("buffer moved", rd_q, 9'h010);
    bus_req.addr <= AUT_OFS_TX_BUFFER;
    bus_req.wdata <= 8'h3C;
    bus_req.we <= 1'b1;
    @(posedge core_clk);
    bus_req.we <= 1'b0;
    bus_req.addr <= AUT_OFS_IRQ_FLAGS;
    bus_req.re <= 1'b1;
    @(posedge core_clk);
    #1 chk("flag stale", {1'b0, bus_rdata}, 9'h010);
    @(posedge core_clk);
    bus_req.re <= 1'b0;
    #1 chk("flag cleared", {1'b0, bus_rdata}, 9'h000);
    @(posedge core_clk);
    wait_q(2);
    chk("first byte", u_node.got_q[0], 9'h0A5);
    chk("second byte", u_node.got_q[1], 9'h03C);
    // the node reports before the stop bit has fully gone out
    repeat (16) @(posedge core_clk);
    rd(AUT_OFS_TX_STATUS);
    chk("shift empty again", rd_q, 9'h026);
    u_node.nbits = 9;
    wr(AUT_OFS_TX_STATUS, 8'h65);
    wr(AUT_OFS_TX_BUFFER, 8'h55);
    wait_q(3);
    chk("ninth bit sent", u_node.got_q[2], 9'h155);
    chk("stop bits", {8'h00, u_node.stop_bad}, 9'h000);
    u_node.nbits = 8;
    wr(AUT_OFS_TX_STATUS, 8'h24);
    wr(AUT_OFS_IRQ_ENABLES, 8'h20);
    pchk("tx req masked", tx_irq_req, 1'b0);
    wr(AUT_OFS_IRQ_ENABLES, 8'h30);
    pchk("tx req enabled", tx_irq_req, 1'b1);
    wr(AUT_OFS_TX_BUFFER, 8'hFF);
    wr(AUT_OFS_TX_BUFFER, 8'h7E);
    rd(AUT_OFS_IRQ_FLAGS);
    chk("buffer full", rd_q, 9'h000);
    // abort only once the start bit is over and the line is high again
    repeat (16) @(posedge core_clk);
    wr(AUT_OFS_TX_STATUS, 8'h04);
    wr(AUT_OFS_TX_STATUS, 8'h24);
    rd(AUT_OFS_IRQ_FLAGS);
    chk("flag set by enable", rd_q, 9'h010);
  endtask
  task automatic t_rx();
    u_node.send(9'h011, 8, 1'b1);
    pchk("no receive when off", rx_irq_req, 1'b0);
    wr(AUT_OFS_RX_STATUS, 8'h90);
    u_node.send(9'h03C, 8, 1'b1);
    pchk("receive request", rx_irq_req, 1'b1);
    wr(AUT_OFS_IRQ_ENABLES, 8'h10);
    pchk("rx req masked", rx_irq_req, 1'b0);
    wr(AUT_OFS_IRQ_ENABLES, 8'h30);
    pchk("rx req unmasked", rx_irq_req, 1'b1);
    rd(AUT_OFS_RX_STATUS);
    chk("rx status clean", rd_q, 9'h090);
    rd(AUT_OFS_RX_BUFFER);
    chk("rx byte", rd_q, 9'h03C);
    rd(AUT_OFS_IRQ_FLAGS);
    chk("rx flag cleared", rd_q, 9'h010);
    u_node.send(9'h0F0, 8, 1'b0);
    rd(AUT_OFS_RX_STATUS);
    chk("framing", rd_q, 9'h094);
    rd(AUT_OFS_RX_BUFFER);
    chk("framed byte", rd_q, 9'h0F0);
    u_node.send(9'h001, 8, 1'b1);
    u_node.send(9'h002, 8, 1'b1);
    rd(AUT_OFS_RX_STATUS);
    chk("overrun", rd_q, 9'h092);
    wr(AUT_OFS_RX_STATUS, 8'h80);
    rd(AUT_OFS_RX_STATUS);
    chk("errors cleared", rd_q, 9'h080);
    rd(AUT_OFS_RX_BUFFER);
    chk("kept byte", rd_q, 9'h001);
  endtask
  task automatic t_addr();
    wr(AUT_OFS_RX_STATUS, 8'hD8);
    u_node.send(9'h0AA, 9, 1'b1);
    pchk("data char kept out", rx_irq_req, 1'b0);
    u_node.send(9'h1A5, 9, 1'b1);
    pchk("address accepted", rx_irq_req, 1'b1);
    rd(AUT_OFS_RX_STATUS);
    chk("ninth bit status", rd_q, 9'h0D9);
    rd(AUT_OFS_RX_BUFFER);
    chk("address byte", rd_q, 9'h0A5);
    wr(AUT_OFS_RX_STATUS, 8'hD0);
    u_node.send(9'h033, 9, 1'b1);
    rd(AUT_OFS_RX_BUFFER);
    chk("all chars in", rd_q, 9'h033);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_tx();
    t_rx();
    t_addr();
    tally_and_finish();
  end
endmodule
